// ==== rtl/scs_conversion_sequencer.sv ====
// Summary of operation
// [RULE_01] Twelve-bit approximation register, one decision each.
// [RULE_02] Full conversion within 20 us or 8 us.
// [RULE_03] Host start pulse high at least 100 ns.
// [RULE_04] Start falling edge resets and begins conversion.
// [RULE_05] Status high in reset and conversion, then low.
// [RULE_06] Parallel result held until next start.
// [RULE_07] Serial decisions NRZ, most significant first.
// [RULE_08] Complementary binary or offset binary coding.
// [RULE_09] Clock output gives 100 ns positive pulses.
// [RULE_10] Grounded strap: 600 kHz or 1.5 MHz.
// [RULE_11] Short cycle stops before twelve decisions.
// [RULE_12] Slow part: 10 bits 15 us, 8 bits 10 us.
// [RULE_13] Truncate input tied to bit after last.
// [RULE_14] External clock: N plus one start pulses.
// [RULE_15] Bits decided MSB first, parallel updated each.
`timescale 1ns/1ns
`default_nettype none
`include "scs_params.svh"
module scs_conversion_sequencer (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic start_conv,
  input wire logic comp_in,
  input wire logic short_cycle,
  input wire logic [1:0] rate_sel,
  input wire logic fast_variant,
  input wire logic ext_clock_mode,
  output logic [`SCS_BITS-1:0] parallel_q,
  output logic busy_q,
  output logic serial_q,
  output logic clk_out_q,
  output logic result_valid,
  input wire logic result_ready,
  output logic [`SCS_BITS-1:0] result_data
);
  // Every pin but resetn and result_ready passes two flip-flops; the first stage feeds only the second.
  logic [6:0] pin_s1_q, pin_s2_q;
  logic start_prev_q;
  logic start_s, comp_s, short_s, fast_s, ext_s;
  logic [1:0] rate_s;

  scs_pkg::scs_state_type state_q, state_d;
  logic [`SCS_BITS-1:0] parallel_d;
  logic [3:0] bit_q, bit_d;
  logic [`SCS_DIV_W-1:0] div_q, div_d;
  logic [`SCS_PULSE_W-1:0] pulse_q, pulse_d;
  logic serial_d, clk_out_d, busy_d;
  logic start_fall, tick, begin_conv, fifo_ready;

  function automatic logic [`SCS_DIV_W-1:0] div_count(input logic fast, input logic [1:0] rate);
    logic [`SCS_DIV_W-1:0] n;
    if (fast)
    begin
      n = (rate == `SCS_RATE_GND) ? `SCS_DIV_W'(`SCS_DIV_CYC(`SCS_FAST_GND_KHZ)) :
          (rate == `SCS_RATE_5V) ? `SCS_DIV_W'(`SCS_DIV_CYC(`SCS_FAST_5V_KHZ)) :
          `SCS_DIV_W'(`SCS_DIV_CYC(`SCS_FAST_15V_KHZ));
    end
    else
    begin
      n = (rate == `SCS_RATE_GND) ? `SCS_DIV_W'(`SCS_DIV_CYC(`SCS_SLOW_GND_KHZ)) :
          (rate == `SCS_RATE_5V) ? `SCS_DIV_W'(`SCS_DIV_CYC(`SCS_SLOW_5V_KHZ)) :
          `SCS_DIV_W'(`SCS_DIV_CYC(`SCS_SLOW_15V_KHZ));
    end
    return n - 1'b1;
  endfunction : div_count

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_s1_q <= 7'h00;
      pin_s2_q <= 7'h00;
      start_prev_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= {ext_clock_mode, fast_variant, rate_sel, short_cycle, comp_in, start_conv};
      pin_s2_q <= pin_s1_q;
      start_prev_q <= pin_s2_q[0];
    end
  end

  always_comb
  begin
    {ext_s, fast_s, rate_s, short_s, comp_s, start_s} = pin_s2_q;
    start_fall = start_prev_q && !start_s;
    // In external mode each start pulse is a bit clock once a conversion runs.
    begin_conv = start_fall && (!ext_s || state_q == scs_pkg::SCS_IDLE); // [RULE_04] [RULE_14]
    tick = ext_s ? (start_fall && !begin_conv) : (div_q == '0); // [RULE_14] [RULE_10]
  end

  always_comb
  begin
    state_d = state_q;
    parallel_d = parallel_q;
    bit_d = bit_q;
    serial_d = serial_q;
    div_d = (div_q == '0) ? div_count(fast_s, rate_s) : div_q - 1'b1; // [RULE_10] [RULE_02] [RULE_12]
    pulse_d = (pulse_q != '0) ? pulse_q - 1'b1 : pulse_q;
    if (begin_conv)
    begin
      // Old result stays up until this moment; the MSB trial shows low.
      state_d = scs_pkg::SCS_CONV; // [RULE_04] [RULE_06]
      parallel_d = `SCS_RESULT_INIT;
      parallel_d[`SCS_MSB] = 1'b0;
      bit_d = `SCS_MSB;
      div_d = div_count(fast_s, rate_s);
      pulse_d = '0;
    end
    else
    begin
      unique case (state_q)
        scs_pkg::SCS_IDLE:
        begin
        end
        scs_pkg::SCS_CONV:
        begin
          // Sampled late in the clock pulse so stale pin levels have settled.
          if (!short_s && pulse_q == `SCS_PULSE_LATE)
          begin
            state_d = scs_pkg::SCS_PUSH; // [RULE_11] [RULE_13]
          end
          else if (tick)
          begin
            // Comparator high gives a one: straight binary coding, not complementary.
            parallel_d[bit_q] = comp_s; // [RULE_01] [RULE_15] [RULE_08]
            serial_d = comp_s; // [RULE_07]
            pulse_d = `SCS_PULSE_W'(`SCS_PULSE_CYC); // [RULE_09]
            if (bit_q == `SCS_LSB)
            begin
              state_d = scs_pkg::SCS_PUSH;
            end
            else
            begin
              parallel_d[bit_q - 1'b1] = 1'b0; // [RULE_15]
              bit_d = bit_q - 1'b1;
            end
          end
        end
        scs_pkg::SCS_PUSH:
        begin
          // A full buffer holds status high rather than losing a result.
          if (fifo_ready)
          begin
            state_d = scs_pkg::SCS_IDLE;
          end
        end
      endcase
    end
    busy_d = (state_d != scs_pkg::SCS_IDLE); // [RULE_05]
    clk_out_d = (pulse_d != '0); // [RULE_09]
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= scs_pkg::SCS_IDLE;
      parallel_q <= `SCS_RESULT_INIT;
      bit_q <= `SCS_MSB;
      div_q <= '0;
      pulse_q <= '0;
      serial_q <= 1'b0;
      clk_out_q <= 1'b0;
      busy_q <= 1'b1; // [RULE_05]
    end
    else
    begin
      state_q <= state_d;
      parallel_q <= parallel_d;
      bit_q <= bit_d;
      div_q <= div_d;
      pulse_q <= pulse_d;
      serial_q <= serial_d;
      clk_out_q <= clk_out_d;
      busy_q <= busy_d;
    end
  end

  scs_fifo #(
    .WIDTH(`SCS_BITS),
    .DEPTH(`SCS_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .in_valid(state_q == scs_pkg::SCS_PUSH && !begin_conv),
    .in_ready(fifo_ready),
    .in_data(parallel_q),
    .out_valid(result_valid),
    .out_ready(result_ready),
    .out_data(result_data)
  );
endmodule : scs_conversion_sequencer
`default_nettype wire

// ==== pkg/scs_params.svh ====
`ifndef SCS_PARAMS_SVH
`define SCS_PARAMS_SVH

`define SCS_CLK_HZ 125000000
`define SCS_CLK_PERIOD_NS 8
`define SCS_BITS 12
`define SCS_MSB 4'hB
`define SCS_LSB 4'h0
`define SCS_RESULT_INIT 12'hFFF
`define SCS_FIFO_DEPTH 8
`define SCS_DIV_W 8
`define SCS_RATE_GND 2'h0
`define SCS_RATE_5V 2'h1
`define SCS_SLOW_GND_KHZ 600
`define SCS_SLOW_5V_KHZ 720
`define SCS_SLOW_15V_KHZ 880
`define SCS_FAST_GND_KHZ 1500
`define SCS_FAST_5V_KHZ 1800
`define SCS_FAST_15V_KHZ 2200
`define SCS_DIV_CYC(k) ((`SCS_CLK_HZ) / ((k) * 1000))
`define SCS_PULSE_NS 100
`define SCS_PULSE_CYC ((`SCS_PULSE_NS + `SCS_CLK_PERIOD_NS - 1) / `SCS_CLK_PERIOD_NS)
`define SCS_PULSE_W 4
`define SCS_PULSE_LATE 4'h1

`endif

// ==== pkg/scs_pkg.sv ====
`default_nettype none
package scs_pkg;
  typedef enum logic [1:0]
  {
    SCS_IDLE = 2'h0,
    SCS_CONV = 2'h1,
    SCS_PUSH = 2'h3
  } scs_state_type;
endpackage : scs_pkg
`default_nettype wire

// ==== rtl/scs_fifo.sv ====
`timescale 1ns/1ns
`default_nettype none
module scs_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic ov_q, ov_d;
  logic [WIDTH-1:0] od_q, od_d;
  logic push, pop;

  // The output word sits in its own register, so the buffer holds one word more than the memory depth.
  always_comb
  begin
    in_ready = (cnt_q != (AW+1)'(DEPTH));
    push = in_valid && in_ready;
    pop = (cnt_q != '0) && (!ov_q || out_ready);
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    ov_d = pop || (ov_q && !out_ready);
    od_d = pop ? mem_q[rp_q] : od_q;
    out_valid = ov_q;
    out_data = od_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      ov_q <= 1'b0;
      od_q <= '0;
    end
    else
    begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      ov_q <= ov_d;
      od_q <= od_d;
    end
  end
endmodule : scs_fifo
`default_nettype wire

// ==== verif/scs_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
module scs_properties (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic start_conv,
  input wire logic short_cycle,
  input wire logic fast_variant,
  input wire logic [11:0] parallel_q,
  input wire logic busy_q,
  input wire logic serial_q,
  input wire logic clk_out_q,
  input wire logic result_valid,
  input wire logic result_ready,
  input wire logic [11:0] result_data
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // The host decides how long a full output stalls, so those cycles are not timed.
  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  always_comb
    cnt_d = busy_q && !start_conv && !(result_valid && !result_ready) ? cnt_q + 12'h001 : 12'h000;
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      cnt_q <= 12'h000;
    else
      cnt_q <= cnt_d;
  sequence pulse_s;
    clk_out_q [*8] ##1 clk_out_q [*5] ##1 !clk_out_q;
  endsequence
  a_clk_width: assert property ($rose(clk_out_q) |-> pulse_s)
    else $error("clk_out width");
  a_start_busy: assert property ($fell(start_conv) |-> ##[1:5] busy_q)
    else $error("busy late");
  a_start_trial: assert property ($rose(busy_q) |-> parallel_q == 12'h7FF)
    else $error("trial value");
  a_serial_step: assert property ($changed(serial_q) |-> $rose(clk_out_q))
    else $error("serial moved");
  a_result_hold: assert property (!busy_q && !$past(busy_q) |-> $stable(parallel_q))
    else $error("parallel moved");
  a_conv_time: assert property (cnt_q <= (fast_variant ? 12'h3F0 : 12'h9CC))
    else $error("conversion long");
  a_short_stop: assert property ($fell(clk_out_q) && !short_cycle && result_ready
    |-> ##[0:20] !busy_q) else $error("short cycle ran on");
  a_short_time: assert property (!short_cycle && !fast_variant && busy_q
    |-> cnt_q <= 12'h4E2) else $error("short cycle slow");
  a_word_hold: assert property (result_valid && !result_ready
    |=> result_valid && $stable(result_data)) else $error("word moved");
endmodule : scs_properties
`default_nettype wire

// ==== verif/scs_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module scs_host_model (
  input wire logic clk_sys,
  input wire logic [11:0] parallel_q,
  input wire logic [11:0] target,
  output logic start_conv,
  output logic comp_in
);
  initial start_conv = 1'b0;
  // The trial code keeps the tested bit low, so a target above it decides a one.
  assign comp_in = target > parallel_q;
  task automatic pulse();
    start_conv <= 1'b1;
    repeat (13) @(posedge clk_sys);
    start_conv <= 1'b0;
  endtask : pulse
endmodule : scs_host_model
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0, resetn = 1'b0, short_en = 1'b0, fast_variant = 1'b1;
  logic result_ready = 1'b1, clk_prev_q = 1'b0, ext_mode = 1'b0;
  logic [1:0] rate_sel = 2'h0;
  logic [11:0] target = 12'h000, ser_q = 12'h000;
  logic start_conv, comp_in, short_cycle, busy_q, serial_q, clk_out_q, result_valid;
  logic [11:0] parallel_q, result_data;
  logic [11:0] words [$];
  int failures = 0, checked = 0, cycles = 0, pulses = 0, t0 = 0, t1 = 0;
  always #4 clk_sys = ~clk_sys;
  // Index 3 follows the eighth decision, so eight bits are kept.
  assign short_cycle = short_en ? parallel_q[3] : 1'b1;
  scs_host_model scs_host_model_inst (.clk_sys, .parallel_q, .target, .start_conv, .comp_in);
  scs_conversion_sequencer scs_conversion_sequencer_inst (.clk_sys, .resetn, .start_conv,
    .comp_in, .short_cycle, .rate_sel, .fast_variant, .ext_clock_mode(ext_mode), .parallel_q,
    .busy_q, .serial_q, .clk_out_q, .result_valid, .result_ready, .result_data);
  always @(posedge clk_sys)
  begin
    clk_prev_q <= clk_out_q;
    cycles <= cycles + 1;
    if (clk_out_q && !clk_prev_q)
    begin
      ser_q <= {ser_q[10:0], serial_q};
      pulses <= pulses + 1;
      if (pulses == 0) t0 <= cycles;
      if (pulses == 1) t1 <= cycles;
    end
    if (result_valid && result_ready) words.push_back(result_data);
    if (cycles == 60000)
    begin
      failures++;
      wrap_up();
    end
  end
  task automatic chk(input string name, input logic [11:0] e, input logic [11:0] got);
    checked++;
    if (got !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, e, got);
    end
  endtask : chk
  task automatic conv(input logic [11:0] t, input logic [11:0] e, input int n, input bit rs);
    target <= t;
    pulses = 0;
    scs_host_model_inst.pulse();
    repeat (6) @(posedge clk_sys);
    chk("busy", 12'h001, {11'h000, busy_q});
    if (rs)
    begin
      for (int i = 0; i < 300 && clk_out_q !== 1'b1; i++) @(posedge clk_sys);
      repeat (20) @(posedge clk_sys);
      chk("first pulse", 12'h001, 12'(pulses));
      scs_host_model_inst.pulse();
      pulses = 0;
      repeat (6) @(posedge clk_sys);
      chk("restart", 12'h7FF, parallel_q);
    end
    for (int i = 0; i < 4000 && busy_q !== 1'b0; i++) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    chk("parallel", e, parallel_q);
    chk("idle", 12'h000, {11'h000, busy_q});
    chk("pulses", 12'(n), 12'(pulses));
    chk("serial", t >> (12 - n), ser_q & ~(12'hFFF << n));
  endtask : conv
  task automatic t_coding();
    logic [11:0] codes [6] = '{12'h000, 12'hFFF, 12'h7FF, 12'h800, 12'hA5A, 12'h5A5};
    chk("reset", 12'hFFF, parallel_q);
    foreach (codes[i])
    begin
      conv(codes[i], codes[i], 12, i == 3);
      chk("word", codes[i], words.pop_front());
    end
  endtask : t_coding
  task automatic t_rates();
    int khz [6] = '{600, 1500, 720, 1800, 880, 2200};
    for (int i = 0; i < 6; i++)
    begin
      rate_sel <= 2'(i / 2 + (i == 5));
      fast_variant <= 1'(i % 2);
      conv(12'h5A5, 12'h5A5, 12, 1'b0);
      chk("period", 12'(125000 / khz[i]), 12'(t1 - t0));
    end
  endtask : t_rates
  task automatic t_fill();
    logic [11:0] v;
    rate_sel <= 2'h0;
    fast_variant <= 1'b1;
    result_ready <= 1'b0;
    words.delete();
    for (int i = 0; i < 9; i++)
    begin
      v = 12'(12'h111 * i);
      conv(v, v, 12, 1'b0);
    end
    target <= 12'hABC;
    scs_host_model_inst.pulse();
    repeat (1500) @(posedge clk_sys);
    chk("stall", 12'h001, {11'h000, busy_q & result_valid});
    result_ready <= 1'b1;
    repeat (1500) @(posedge clk_sys);
    for (int i = 0; i < 10; i++)
      chk("drain", i < 9 ? 12'(12'h111 * i) : 12'hABC, words.pop_front());
  endtask : t_fill
  // Each start fall after the first clocks one decision, so twelve bits take thirteen pulses.
  task automatic t_ext();
    ext_mode <= 1'b1;
    target <= 12'h9C6;
    pulses = 0;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 13; i++)
    begin
      chk("ext busy", 12'(i > 0), {11'h000, busy_q});
      scs_host_model_inst.pulse();
      repeat (20) @(posedge clk_sys);
    end
    chk("ext parallel", 12'h9C6, parallel_q);
    chk("ext pulses", 12'h00C, 12'(pulses));
    chk("ext serial", 12'h9C6, ser_q);
    chk("ext idle", 12'h000, {11'h000, busy_q});
    chk("ext word", 12'h9C6, words.pop_front());
    ext_mode <= 1'b0;
  endtask : t_ext
  task automatic wrap_up();
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (3) @(posedge clk_sys);
    chk("reset busy", 12'h001, {11'h000, busy_q});
    resetn <= 1'b1;
    @(posedge clk_sys);
    t_coding();
    t_rates();
    rate_sel <= 2'h2;
    fast_variant <= 1'b0;
    short_en <= 1'b1;
    conv(12'hC35, 12'hC37, 8, 1'b0);
    short_en <= 1'b0;
    t_fill();
    t_ext();
    wrap_up();
  end
endmodule : tb_top
bind scs_conversion_sequencer scs_properties scs_properties_inst (.clk_sys, .resetn,
  .start_conv, .short_cycle, .fast_variant, .parallel_q, .busy_q, .serial_q, .clk_out_q,
  .result_valid, .result_ready, .result_data);
`default_nettype wire
